// ### verilog/usb_bus_event_status.sv
// usb bus event and status registers with axi4-lite slave
`timescale 1ns/1ps
module usb_bus_event_status (
   input wire logic core_clk,
   input wire logic nrst,
   // axi4-lite
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // engine side (usb clock domain levels)
   input wire usb_evt_pkg::engine_evt_t engine_evt,
   input wire logic stack_full,
   output logic remote_wakeup_request,
   output logic bus_reset_to_core,
   output usb_evt_pkg::pin_cfg_t pin_cfg,
   output logic irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic bus_reset_to_core_enable;
   logic [2:0] pin_function_mode_select;
   logic bus_reset_flag;
   logic suspend_indication;
   logic resume_indication;
   logic [3:0] endpoint_access_flags;
   logic [3:0] ep_irq_enable;
   logic flag_write_protect;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   usb_evt_pkg::engine_evt_t evt_sync;
   usb_evt_pkg::engine_evt_t evt_prev;
   logic [3:0] ep_rise;
   logic rst_rise;
   logic suspend_indication_rise;
   logic res_rise;

   // ----------------------------------------------------------------
   // crossing from the engine domain
   // ----------------------------------------------------------------
   sync2 #(.W($bits(usb_evt_pkg::engine_evt_t))) u_sync (
      .core_clk(core_clk),
      .nrst(nrst),
      .d(engine_evt),
      .q(evt_sync)
   ); // [RULE19]

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         evt_prev <= '0;
      end else begin
         evt_prev <= evt_sync;
      end
   end

   assign ep_rise = evt_sync.ep_access & ~evt_prev.ep_access;
   assign rst_rise = evt_sync.bus_reset & ~evt_prev.bus_reset;
   assign suspend_indication_rise = evt_sync.suspend & ~evt_prev.suspend; // [RULE14]
   assign res_rise = evt_sync.resume & ~evt_prev.resume;

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic rd_fire;
   logic [31:0] rd_val;
   logic rd_ok;
   logic wr_ok;

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == usb_evt_pkg::ADDR_CTRL_STATUS) || (a == usb_evt_pkg::ADDR_EP_FLAGS) ||
         (a == usb_evt_pkg::ADDR_EP_ENABLE) || (a == usb_evt_pkg::ADDR_MISC) ||
         (a == usb_evt_pkg::ADDR_IRQ_STATUS) || (a == usb_evt_pkg::ADDR_IRQ_MASK);
   endfunction

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;
   assign wr_ok = wr_fire && w_strb[0];

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= usb_evt_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_known(aw_addr) ? usb_evt_pkg::RESP_OKAY : usb_evt_pkg::RESP_DECERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_val = 32'h00000000;
      rd_ok = 1'b1;
      case ({s_axi_araddr[7:2], 2'b00})
         usb_evt_pkg::ADDR_CTRL_STATUS: begin
            rd_val[7:0] = {bus_reset_to_core_enable, pin_function_mode_select, resume_indication,
               bus_reset_flag, remote_wakeup_request, suspend_indication};
         end
         usb_evt_pkg::ADDR_EP_FLAGS: begin
            rd_val[3:0] = endpoint_access_flags; // [RULE17]
         end
         usb_evt_pkg::ADDR_EP_ENABLE: begin
            rd_val[3:0] = ep_irq_enable;
         end
         usb_evt_pkg::ADDR_MISC: begin
            rd_val[usb_evt_pkg::BIT_WRITE_PROTECT] = flag_write_protect;
         end
         usb_evt_pkg::ADDR_IRQ_STATUS: begin
            rd_val[3:0] = irq_status;
         end
         usb_evt_pkg::ADDR_IRQ_MASK: begin
            rd_val[3:0] = irq_mask;
         end
         default: begin
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= usb_evt_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? usb_evt_pkg::RESP_OKAY : usb_evt_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   logic wr_ctrl;
   logic wr_epf;
   assign wr_ctrl = wr_ok && (aw_addr == usb_evt_pkg::ADDR_CTRL_STATUS);
   assign wr_epf = wr_ok && (aw_addr == usb_evt_pkg::ADDR_EP_FLAGS);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         bus_reset_to_core_enable <= usb_evt_pkg::RESET_TO_CORE_RST; // [RULE1]
         pin_function_mode_select <= usb_evt_pkg::MODE_RST;
         remote_wakeup_request <= 1'b0;
      end else if (wr_ctrl) begin
         bus_reset_to_core_enable <= w_data[usb_evt_pkg::BIT_RESET_TO_CORE];
         pin_function_mode_select <= w_data[usb_evt_pkg::BIT_MODE_LO +: 3];
         // level held while set; software keeps it long enough for the engine
         remote_wakeup_request <= w_data[usb_evt_pkg::BIT_WAKEUP]; // [RULE12] [RULE13]
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ep_irq_enable <= 4'h0;
         flag_write_protect <= 1'b0;
         irq_mask <= 4'h0;
      end else if (wr_ok) begin
         if (aw_addr == usb_evt_pkg::ADDR_EP_ENABLE) begin
            ep_irq_enable <= w_data[3:0]; // [RULE18]
         end
         if (aw_addr == usb_evt_pkg::ADDR_MISC) begin
            flag_write_protect <= w_data[usb_evt_pkg::BIT_WRITE_PROTECT];
         end
         if (aw_addr == usb_evt_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= w_data[3:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // engine-owned flags
   // ----------------------------------------------------------------
   // bus reset flag: set wins over a same-cycle software clear
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         bus_reset_flag <= 1'b0;
      end else if (rst_rise) begin
         bus_reset_flag <= 1'b1; // [RULE9] [RULE19]
      end else if (wr_ctrl && !flag_write_protect) begin
         bus_reset_flag <= w_data[usb_evt_pkg::BIT_BUS_RESET]; // [RULE10] [RULE11]
      end
   end

   // suspend drops first; resume follows one cycle later
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         suspend_indication <= 1'b0;
         resume_indication <= 1'b0;
      end else begin
         suspend_indication <= evt_sync.suspend; // [RULE14]
         if (res_rise) begin
            resume_indication <= 1'b1; // [RULE6]
         end else if (!suspend_indication && !evt_sync.suspend) begin
            resume_indication <= 1'b0; // [RULE7]
         end
      end
   end

   // endpoint flags: engine sets, only software clears; set beats clear
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         endpoint_access_flags <= 4'h0;
      end else begin
         for (int i = 0; i < usb_evt_pkg::NUM_EP; i++) begin
            if (ep_rise[i]) begin
               endpoint_access_flags[i] <= 1'b1; // [RULE15] [RULE19]
            end else if (wr_epf && !w_data[i]) begin
               endpoint_access_flags[i] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt status: sticky, cleared by reading it
   // ----------------------------------------------------------------
   logic [3:0] irq_set;
   logic irq_rd;
   assign irq_set[usb_evt_pkg::IRQ_SUSPEND] = suspend_indication_rise; // [RULE14]
   assign irq_set[usb_evt_pkg::IRQ_RESUME] = res_rise; // [RULE6]
   assign irq_set[usb_evt_pkg::IRQ_BUS_RESET] = rst_rise; // [RULE9]
   assign irq_set[usb_evt_pkg::IRQ_ENDPOINT] = |(ep_rise & ep_irq_enable); // [RULE15] [RULE18]
   assign irq_rd = rd_fire && ({s_axi_araddr[7:2], 2'b00} == usb_evt_pkg::ADDR_IRQ_STATUS);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         irq_status <= 4'h0;
      end else begin
         irq_status <= (irq_rd ? 4'h0 : irq_status) | irq_set;
      end
   end

   // a full stack holds the request back rather than losing it
   assign irq = |(irq_status & irq_mask) && !stack_full; // [RULE15]

   // ----------------------------------------------------------------
   // pin function decode
   // ----------------------------------------------------------------
   always_comb begin
      pin_cfg = '0;
      case (pin_function_mode_select)
         usb_evt_pkg::MODE_FLOAT: pin_cfg.pins_float = 1'b1; // [RULE2]
         usb_evt_pkg::MODE_OPEN_DRAIN: begin
            pin_cfg.regulator_pullup = 1'b1; // [RULE3]
            pin_cfg.od_mode = 1'b1;
         end
         3'h2, 3'h3: begin
            pin_cfg.regulator_en = 1'b1; // [RULE4]
            pin_cfg.usb_mode = 1'b1;
         end
         default: pin_cfg.pins_float = 1'b1; // [RULE5]
      endcase
   end

   assign bus_reset_to_core = bus_reset_to_core_enable && rst_rise; // [RULE1]

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence rst_edge_s;
      engine_evt.bus_reset && !$past(engine_evt.bus_reset);
   endsequence

   bus_reset_set_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE9]
      rst_rise |=> bus_reset_flag) else $error("bus reset flag not set");
   protect_hold_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE10]
      (wr_ctrl && flag_write_protect && !rst_rise) |=> $stable(bus_reset_flag))
      else $error("protected flag changed");
   rst_sync_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE19]
      rst_edge_s ##0 $past(nrst) |-> ##[2:3] bus_reset_flag)
      else $error("bus reset not seen in time");
   core_reset_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE1]
      rst_rise |-> (bus_reset_to_core == bus_reset_to_core_enable)) else $error("core reset choice ignored");
   usb_mode_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE4]
      (pin_function_mode_select[2:1] == 2'h1) |-> (pin_cfg.usb_mode && pin_cfg.regulator_en))
      else $error("usb mode not decoded");
   undef_float_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE5]
      pin_function_mode_select[2] |-> (pin_cfg.pins_float && !pin_cfg.od_mode))
      else $error("undefined mode drives pins");
   resume_set_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE6]
      res_rise |=> (resume_indication && irq_status[usb_evt_pkg::IRQ_RESUME]))
      else $error("resume not flagged");
   // resume must outlive suspend by one cycle, then drop
   resume_order_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE7]
      ($fell(suspend_indication) && $past(resume_indication)) |-> resume_indication)
      else $error("resume cleared with suspend");
   resume_clear_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE7]
      ($fell(suspend_indication) && !evt_sync.suspend && !res_rise) |=> !resume_indication)
      else $error("resume not cleared after suspend");
   suspend_indication_irq_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE14]
      (suspend_indication_rise && !irq_rd) |=> irq_status[usb_evt_pkg::IRQ_SUSPEND])
      else $error("suspend irq missing");
   ep_sticky_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE15]
      (endpoint_access_flags[0] && !(wr_epf && !w_data[0])) |=> endpoint_access_flags[0])
      else $error("endpoint flag lost");
   ep_gate_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE18]
      ((ep_rise & ep_irq_enable) == 4'h0 && !irq_rd) |=> $stable(irq_status[usb_evt_pkg::IRQ_ENDPOINT]))
      else $error("disabled endpoint raised irq");
   irq_stack_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE15]
      stack_full |-> !irq) else $error("irq raised with full stack");
   wake_level_a: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE12]
      wr_ctrl |=> (remote_wakeup_request == $past(w_data[usb_evt_pkg::BIT_WAKEUP])))
      else $error("wake-up request not taken");
endmodule

// ### verilog/usb_evt_pkg.sv
// constants and carriers for the usb bus event and status block
// Contract
// RULE1: bit 7 chooses whether a bus reset also resets the core; powers up 1
// RULE2: mode 000 floats the regulator output and the bus pins
// RULE3: mode 001 pulls regulator high; bus pins open-drain with pull-ups
// RULE4: mode 01x enables the regulator and uses pins as usb data lines
// RULE5: modes 100 to 111 are undefined; open-drain pins left floating
// RULE6: a resume sets read-only bit 3 and raises a waking interrupt
// RULE7: leaving suspend clears the suspend bit first, then the resume bit
// RULE8: software enables usb clock and clears current reduction to see suspend
// RULE9: a bus reset sets flag bit 2 and raises the usb interrupt
// RULE10: software clears the bus reset flag only while write protect is 0
// RULE11: write protect 0 allows writes to engine-owned bits, 1 blocks them; code gates only the bus reset flag, endpoint flag clears ignore it
// RULE12: writing 1 to bit 1 starts remote wake-up signalling
// RULE13: software holds the wake-up bit high at least one usb clock
// RULE14: suspend sets read-only bit 0; its rising edge raises an interrupt
// RULE15: endpoint access sets its flag; interrupt if enabled and stack not full
// RULE16: software clears endpoint flags after service; engine never clears them
// RULE17: endpoint flags in bits 3..0; bits 7..4 read as zero
// RULE18: each endpoint has its own interrupt enable bit
// RULE19: engine events are synchronised before software sees them; set beats clear
package usb_evt_pkg;

   localparam logic [7:0] ADDR_CTRL_STATUS = 8'h00;
   localparam logic [7:0] ADDR_EP_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_EP_ENABLE = 8'h08;
   localparam logic [7:0] ADDR_MISC = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

   localparam int BIT_RESET_TO_CORE = 7;
   localparam int BIT_MODE_LO = 4;
   localparam int BIT_RESUME = 3;
   localparam int BIT_BUS_RESET = 2;
   localparam int BIT_WAKEUP = 1;
   localparam int BIT_SUSPEND = 0;
   localparam int BIT_WRITE_PROTECT = 0;
   localparam int NUM_EP = 4;

   localparam logic RESET_TO_CORE_RST = 1'h1;
   localparam logic [2:0] MODE_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // irq status / mask bit positions
   localparam int IRQ_SUSPEND = 0;
   localparam int IRQ_RESUME = 1;
   localparam int IRQ_BUS_RESET = 2;
   localparam int IRQ_ENDPOINT = 3;

   // pin function mode codes
   localparam logic [2:0] MODE_FLOAT = 3'h0;
   localparam logic [2:0] MODE_OPEN_DRAIN = 3'h1;

   typedef struct packed {
      logic bus_reset;
      logic suspend;
      logic resume;
      logic [3:0] ep_access;
   } engine_evt_t;

   typedef struct packed {
      logic regulator_en;
      logic regulator_pullup;
      logic usb_mode;
      logic od_mode;
      logic pins_float;
   } pin_cfg_t;

endpackage

// ### verilog/sync2.sv
// two-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ### dv/usb_engine_model.sv
// behavioural serial engine that raises bus event levels toward the status block
`timescale 1ns/1ps
module usb_engine_model (
   input wire logic core_clk,
   input wire logic bus_reset_req,
   input wire logic suspend_req,
   input wire logic resume_req,
   input wire logic [3:0] ep_req,
   input wire logic remote_wakeup_request,
   output usb_evt_pkg::engine_evt_t engine_evt
);
   initial engine_evt = '0;
   // ----------------------------------------
   // event levels
   // ----------------------------------------
   always @(posedge core_clk) begin
      engine_evt.bus_reset <= bus_reset_req;
      engine_evt.ep_access <= ep_req;
      if (suspend_req) begin
         // software is taken to run the usb clock with current reduction off
         engine_evt.suspend <= 1'b1;
         // the host answers a wake-up request with resume signalling
         if (resume_req || remote_wakeup_request) begin
            engine_evt.resume <= 1'b1;
         end
      end else begin
         engine_evt.suspend <= 1'b0;
         if (!engine_evt.suspend) begin
            engine_evt.resume <= 1'b0;
         end
      end
   end
endmodule

// ### dv/usb_bus_event_status_bench.sv
// self-checking bench for the usb bus event and status block
`timescale 1ns/1ps
module usb_bus_event_status_bench;
   logic core_clk, nrst;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
   logic [3:0] s_axi_wstrb, ep_req;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
   logic stack_full, remote_wakeup_request, bus_reset_to_core, irq;
   logic bus_reset_req, suspend_req, resume_req;
   usb_evt_pkg::engine_evt_t engine_evt;
   usb_evt_pkg::pin_cfg_t pin_cfg;
   logic [4:0] exp_pins [8];
   int err_count = 0;
   int n_checks = 0;
   int core_resets = 0;

   usb_bus_event_status u_dut (.core_clk(core_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .engine_evt(engine_evt), .stack_full(stack_full),
      .remote_wakeup_request(remote_wakeup_request), .bus_reset_to_core(bus_reset_to_core),
      .pin_cfg(pin_cfg), .irq(irq));

   usb_engine_model u_engine (.core_clk(core_clk), .bus_reset_req(bus_reset_req),
      .suspend_req(suspend_req), .resume_req(resume_req), .ep_req(ep_req),
      .remote_wakeup_request(remote_wakeup_request), .engine_evt(engine_evt));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // counts core reset pulses so a pulse that is missing or too long shows up
   always @(posedge core_clk) begin
      if (bus_reset_to_core === 1'b1) begin
         core_resets <= core_resets + 1;
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      resp_q = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n >= 100) err_count++;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n >= 100) err_count++;
      @(posedge core_clk);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // the whole sequence needs only a few hundred cycles
   initial begin
      #400000;
      err_count++;
      wrap_up();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ep_req} = '0;
      s_axi_wstrb = 4'hF;
      {stack_full, bus_reset_req, suspend_req, resume_req} = '0;
      exp_pins = '{5'h01, 5'h0A, 5'h14, 5'h14, 5'h01, 5'h01, 5'h01, 5'h01};
      settle(4);
      nrst <= 1'b1;
      @(posedge core_clk);
      rd(8'h00);
      chk(rd_q, 32'h80);
      chk(32'(pin_cfg), 32'h01);
      rd(8'h04);
      chk(rd_q, 32'h00);
      $display("test reset done");

      for (int m = 0; m < 8; m++) begin
         wr(8'h00, 32'h80 | (m << 4));
         chk(32'(pin_cfg), 32'(exp_pins[m]));
         rd(8'h00);
         chk(rd_q, 32'h80 | (m << 4));
      end
      $display("test pin modes done");

      wr(8'h14, 32'h04);
      wr(8'h00, 32'h80);
      bus_reset_req <= 1'b1;
      settle(6);
      rd(8'h00);
      chk(rd_q, 32'h84);
      chk(core_resets, 1);
      chk(irq, 1'b1);
      rd(8'h10);
      chk(rd_q, 32'h04);
      settle(2);
      chk(irq, 1'b0);
      bus_reset_req <= 1'b0;
      wr(8'h0C, 32'h01);
      wr(8'h00, 32'h80);
      rd(8'h00);
      chk(rd_q, 32'h84);
      wr(8'h0C, 32'h00);
      wr(8'h00, 32'h00);
      rd(8'h00);
      chk(rd_q, 32'h00);
      bus_reset_req <= 1'b1;
      settle(6);
      bus_reset_req <= 1'b0;
      chk(core_resets, 1);
      wr(8'h00, 32'h00);
      rd(8'h10);
      chk(rd_q, 32'h04);
      $display("test bus reset done");

      wr(8'h14, 32'h03);
      suspend_req <= 1'b1;
      settle(6);
      rd(8'h00);
      chk(rd_q, 32'h01);
      chk(irq, 1'b1);
      rd(8'h10);
      chk(rd_q, 32'h01);
      wr(8'h00, 32'h02);
      chk(remote_wakeup_request, 1'b1);
      // several core cycles cover one slower usb clock
      settle(6);
      rd(8'h00);
      chk(rd_q, 32'h0B);
      chk(irq, 1'b1);
      rd(8'h10);
      chk(rd_q, 32'h02);
      wr(8'h00, 32'h00);
      suspend_req <= 1'b0;
      settle(8);
      rd(8'h00);
      chk(rd_q, 32'h00);
      rd(8'h10);
      chk(rd_q, 32'h00);
      $display("test suspend resume done");

      wr(8'h14, 32'h08);
      wr(8'h08, 32'h05);
      stack_full <= 1'b1;
      ep_req <= 4'hF;
      settle(6);
      ep_req <= 4'h0;
      settle(4);
      chk(irq, 1'b0);
      stack_full <= 1'b0;
      settle(2);
      chk(irq, 1'b1);
      rd(8'h04);
      chk(rd_q, 32'h0F);
      rd(8'h10);
      chk(rd_q, 32'h08);
      wr(8'h04, 32'hFFFF_FFF0);
      rd(8'h04);
      chk(rd_q, 32'h00);
      wr(8'h08, 32'h02);
      ep_req <= 4'h8;
      settle(6);
      ep_req <= 4'h0;
      settle(2);
      rd(8'h10);
      chk(rd_q, 32'h00);
      rd(8'h04);
      chk(rd_q, 32'h08);
      $display("test endpoints done");

      rd(8'h20);
      chk(resp_q, usb_evt_pkg::RESP_DECERR);
      wr(8'h24, 32'h00);
      chk(resp_q, usb_evt_pkg::RESP_DECERR);
      wr(8'h00, 32'h0000_FF00);
      rd(8'h00);
      chk(rd_q, 32'h00);
      $display("test unmapped done");
      wrap_up();
   end
endmodule
